/* hw/scmc_pkg.sv */
// Package: constants, register map and types of the system clock mode control block
package scmc_pkg;
   // ******************************************************************
   // Clock rate and oscillator models
   // ******************************************************************
   localparam int CLK_HZ        = 50_000_000;   // Block clock rate
   localparam int FAST_HZ_8     = 8_000_000;    // Fast RC setting 8 MHz
   localparam int FAST_HZ_12    = 12_000_000;   // Fast RC setting 12 MHz
   localparam int FAST_HZ_16    = 16_000_000;   // Fast RC setting 16 MHz
   localparam int SLOW_HZ       = 32_000;       // Slow RC nominal rate
   localparam int PER_W         = 11;           // Width of a tick period
   // Longest whole number of block cycles per oscillator period
   localparam logic [PER_W-1:0] FAST_PER_8  = PER_W'(CLK_HZ / FAST_HZ_8);
   localparam logic [PER_W-1:0] FAST_PER_12 = PER_W'(CLK_HZ / FAST_HZ_12);
   localparam logic [PER_W-1:0] FAST_PER_16 = PER_W'(CLK_HZ / FAST_HZ_16);
   localparam logic [PER_W-1:0] SLOW_PER    = PER_W'(CLK_HZ / SLOW_HZ);
   localparam int STAB_W        = 16;           // Width of settle counters
   localparam logic [STAB_W-1:0] FAST_STAB_CYC = 16'h0100; // Fast RC settle
   localparam logic [STAB_W-1:0] SLOW_STAB_CYC = 16'h0040; // Slow RC settle
   localparam logic [2:0] SW_CUR_PERIODS = 3'h4; // Current periods before switch

   // ******************************************************************
   // Register map (byte addresses)
   // ******************************************************************
   localparam logic [7:0] ADDR_SYS_CLK_CTRL = 8'h00; // system_clock_control
   localparam logic [7:0] ADDR_FAST_RC_CTRL = 8'h04; // high_speed_rc_control
   localparam logic [7:0] ADDR_STATUS       = 8'h08; // Live block state
   localparam logic [7:0] ADDR_IRQ_STAT     = 8'h0C; // Sticky events, W1C
   localparam logic [7:0] ADDR_IRQ_MASK     = 8'h10; // Interrupt mask

   // system_clock_control fields
   localparam int SCC_SEL_LSB   = 5;            // sys_clk_select at 7:5
   localparam int SCC_FAST_KEEP = 1;            // fast_osc_halt_keep
   localparam int SCC_SLOW_KEEP = 0;            // slow_osc_halt_keep
   localparam logic [7:0] SCC_RESET = 8'h00;
   // high_speed_rc_control fields
   localparam int FRC_FREQ_LSB  = 2;            // fast_rc_freq_select at 3:2
   localparam int FRC_STABLE    = 1;            // fast_rc_stable_flag, RO
   localparam int FRC_ENABLE    = 0;            // fast_rc_enable
   localparam logic [7:0] FRC_RESET = 8'h01;
   // status fields
   localparam int ST_SRC_LSB    = 0;            // Active selection at 2:0
   localparam int ST_BUSY       = 3;            // Switch in progress
   localparam int ST_MODE_LSB   = 4;            // Operating mode at 6:4
   localparam int ST_SLOW_STAB  = 7;            // Slow RC settled
   // interrupt events
   localparam int IRQ_N         = 4;
   localparam int EV_FAST_STAB  = 0;            // Fast RC became stable
   localparam int EV_SW_DONE    = 1;            // Clock switch completed
   localparam int EV_HALT       = 2;            // Halt mode entered
   localparam int EV_WAKE       = 3;            // Returned to run

   localparam logic [2:0] SEL_SLOW = 3'h7;      // Select code of slow clock
   localparam logic [1:0] FREQ_12  = 2'h1;
   localparam logic [1:0] FREQ_16  = 2'h2;

   // ******************************************************************
   // Types
   // ******************************************************************
   typedef enum logic [2:0] {
      MODE_RUN, MODE_SLEEP, MODE_IDLE_SLOW, MODE_IDLE_BOTH, MODE_IDLE_FAST
   } scmc_mode_t;
   typedef enum logic [1:0] {SW_IDLE, SW_CUR, SW_TGT} scmc_sw_t;
endpackage : scmc_pkg

/* hw/scmc_tick_div.sv */
// Module: enable pulse generator, one pulse per programmable period
`timescale 1ns/1ps
module scmc_tick_div #(
   parameter int W = 11
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         run,     // Oscillator running
   input  wire logic [W-1:0] period,  // Cycles per pulse
   output logic              tick_r   // One-cycle pulse
);
   logic [W-1:0] cnt_r;                // Cycles left in this period

   // Count down, pulse on wrap; stopped oscillator holds phase zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (!run) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r <= W'(1)) begin
         cnt_r  <= period;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r - W'(1);
         tick_r <= 1'b0;
      end
   end
endmodule : scmc_tick_div

/* hw/scmc_clock_ctrl.sv */
// Module: system clock source, divider, oscillator and halt mode control
//
// What this block does
// R1: Select field picks fast divided or slow
// R2: Fast keep bit holds fast osc in halt while enable bit set
// R3: Slow keep bit holds slow osc in halt
// R4: Switch waits four current periods, then target
// R5: Frequency field picks 8, 12, 16, 8 MHz
// R6: New frequency applied only once stable
// R7: Enable write from 0 to 1 or frequency change clears, then sets flag
// R8: Enable bit turns fast oscillator off or on
// R9: Software matches frequency field to configuration
// R10: Select field switches speed; halt picks low-power mode
// R11: Slow switch completes only with slow osc stable
// R12: Return to fast waits for fast osc restart
// R13: Unimplemented bits read zero, ignore writes
// R14: Keep bits map halt to sleep or idles
// R15: Fast osc stops on slow source unless enabled
// R16: Source switch never shortens a clock pulse
`timescale 1ns/1ps
module scmc_clock_ctrl
   import scmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Processor side
   input  wire logic        halt_req,       // Halt instruction executed
   input  wire logic        wake_req,       // Any wake-up source
   output logic             sys_clk_en,     // System clock pulse
   output logic             cpu_clk_en,     // Processor clock pulse
   output logic             fast_clk_en,    // Fast clock pulse for peripherals
   output logic             slow_clk_en,    // Slow clock pulse for peripherals
   output logic             fast_osc_on,    // Fast RC running
   output logic             slow_osc_on,    // Slow RC running
   output logic             irq
);
   import scmc_pkg::*;

   // ******************************************************************
   // Declarations
   // ******************************************************************
   logic [2:0]         sel_r;           // sys_clk_select as written
   logic               fast_keep_r;     // fast_osc_halt_keep
   logic               slow_keep_r;     // slow_osc_halt_keep
   logic [1:0]         freq_sel_r;      // fast_rc_freq_select as written
   logic [1:0]         freq_act_r;      // Frequency the oscillator runs at
   logic               fast_en_r;       // fast_rc_enable
   logic               stable_r;        // fast_rc_stable_flag
   logic               slow_stable_r;   // Slow RC settled
   logic [STAB_W-1:0]  stab_cnt_r;      // Fast settle count
   logic [STAB_W-1:0]  slow_cnt_r;      // Slow settle count
   logic [2:0]         cur_src_r;       // Selection now driving the clock
   scmc_sw_t           sw_r;            // Switch sequencer state
   logic [2:0]         sw_cnt_r;        // Current periods seen
   scmc_mode_t         mode_r;          // Run or low-power mode
   logic [5:0]         div_cnt_r;       // Fast ticks for the divider
   logic [IRQ_N-1:0]   irq_stat_r;      // Sticky events
   logic [IRQ_N-1:0]   irq_mask_r;      // Event enables
   logic [IRQ_N-1:0]   ev;              // Events this cycle
   logic               fast_tick;       // Fast oscillator pulse
   logic               slow_tick;       // Slow oscillator pulse
   logic [PER_W-1:0]   fast_per;        // Fast period from applied frequency
   logic               halted;          // Processor switched off
   logic               fast_on_nxt;
   logic               slow_on_nxt;
   logic               src_tick;        // Pulse of the current source
   logic               tgt_tick;        // Pulse of the target source
   logic               tgt_ready;       // Target source stable
   logic               wr_go;           // Write completes this edge
   logic               restart;         // Fast settle must restart
   logic [5:0]         cur_mask;
   logic [5:0]         tgt_mask;

   assign halted = (mode_r != MODE_RUN);
   assign wr_go  = psel & penable & pwrite & pready;

   // ******************************************************************
   // Oscillator models
   // ******************************************************************
   // Applied frequency to period
   always_comb begin
      unique case (freq_act_r)
         FREQ_12: fast_per = FAST_PER_12;
         FREQ_16: fast_per = FAST_PER_16;
         default: fast_per = FAST_PER_8;  // Codes 00 and 11 both give 8 MHz  see R5
      endcase
   end

   scmc_tick_div #(.W(PER_W)) u_fast (
      .clk    (clk),
      .resetn (resetn),
      .run    (fast_on_nxt),  // Next-state enable: no pulse trails a stop
      .period (fast_per),
      .tick_r (fast_tick)
   );

   scmc_tick_div #(.W(PER_W)) u_slow (
      .clk    (clk),
      .resetn (resetn),
      .run    (slow_on_nxt),  // Next-state enable: no pulse trails a stop
      .period (SLOW_PER),
      .tick_r (slow_tick)
   );

   // Which oscillators run in the present mode
   always_comb begin
      // Fast needed while running on it or switching toward it
      if (fast_en_r) begin
         fast_on_nxt = !halted | fast_keep_r;           // see R2, R8
      end else begin
         fast_on_nxt = !halted & ((cur_src_r != SEL_SLOW) |
                                  (sel_r != SEL_SLOW));  // see R15, R8
      end
      slow_on_nxt = !halted | slow_keep_r;              // see R3
   end

   // Oscillator enables
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fast_osc_on <= 1'b0;
         slow_osc_on <= 1'b0;
      end else begin
         fast_osc_on <= fast_on_nxt;
         slow_osc_on <= slow_on_nxt;
      end
   end

   // ******************************************************************
   // Fast RC settle and stable flag
   // ******************************************************************
   assign restart = (fast_on_nxt & !fast_osc_on) |
                    (wr_go & (paddr == ADDR_FAST_RC_CTRL) &
                     ((pwdata[FRC_FREQ_LSB +: 2] != freq_sel_r) |
                      (pwdata[FRC_ENABLE] & !fast_en_r)));

   // Flag cleared on restart, set after settle; frequency applied then
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stab_cnt_r <= '0;
         stable_r   <= 1'b0;
         freq_act_r <= '0;
      end else if (restart || !fast_osc_on) begin
         stab_cnt_r <= '0;
         stable_r   <= 1'b0;                            // see R7
      end else if (!stable_r) begin
         if (stab_cnt_r >= FAST_STAB_CYC - STAB_W'(1)) begin
            stable_r   <= 1'b1;                         // see R7
            freq_act_r <= freq_sel_r;                   // see R6
         end else begin
            stab_cnt_r <= stab_cnt_r + STAB_W'(1);
         end
      end
   end

   // Slow RC settle after start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slow_cnt_r    <= '0;
         slow_stable_r <= 1'b0;
      end else if (!slow_osc_on) begin
         slow_cnt_r    <= '0;
         slow_stable_r <= 1'b0;
      end else if (slow_cnt_r >= SLOW_STAB_CYC - STAB_W'(1)) begin
         slow_stable_r <= 1'b1;
      end else begin
         slow_cnt_r <= slow_cnt_r + STAB_W'(1);
      end
   end

   // ******************************************************************
   // System clock divider and source switch
   // ******************************************************************
   // Free count of fast ticks; divided pulses align to it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_r <= '0;
      end else if (fast_tick) begin
         div_cnt_r <= div_cnt_r + 6'h01;
      end
   end

   // Pulses of current and target selections
   always_comb begin
      cur_mask  = 6'(({6'h00, 1'b1} << cur_src_r[2:0]) - 7'h01);
      tgt_mask  = 6'(({6'h00, 1'b1} << sel_r[2:0]) - 7'h01);
      // Code 111 is slow, others fast divided by 2**code  see R1
      src_tick  = (cur_src_r == SEL_SLOW) ? slow_tick :
                  (fast_tick & ((div_cnt_r & cur_mask) == 6'h00));
      tgt_tick  = (sel_r == SEL_SLOW) ? slow_tick :
                  (fast_tick & ((div_cnt_r & tgt_mask) == 6'h00));
      // Slow needs settled slow osc, fast needs the stable flag
      tgt_ready = (sel_r == SEL_SLOW) ? slow_stable_r : stable_r; // see R11, R12
   end

   // Switch sequencer: four current periods, then a target edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sw_r      <= SW_IDLE;
         sw_cnt_r  <= '0;
         cur_src_r <= '0;
      end else begin
         unique case (sw_r)
            SW_IDLE: begin
               sw_cnt_r <= '0;
               if (sel_r != cur_src_r) begin             // see R10
                  sw_r <= SW_CUR;
               end
            end
            SW_CUR: begin
               if (sw_cnt_r >= SW_CUR_PERIODS) begin
                  sw_r <= SW_TGT;                        // see R4
               end else if (src_tick) begin
                  sw_cnt_r <= sw_cnt_r + 3'h1;
               end
            end
            SW_TGT: begin
               if (sel_r == cur_src_r) begin
                  sw_r <= SW_IDLE;                       // Selection reverted
               end else if (tgt_ready && tgt_tick) begin
                  // Hand over on a target edge; the old source still drives this cycle's pulse  see R16
                  cur_src_r <= sel_r;
                  sw_r      <= SW_IDLE;
               end
            end
         endcase
      end
   end

   // Clock enable outputs; processor clock stops while halted
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sys_clk_en  <= 1'b0;
         cpu_clk_en  <= 1'b0;
         fast_clk_en <= 1'b0;
         slow_clk_en <= 1'b0;
      end else begin
         sys_clk_en  <= src_tick;
         cpu_clk_en  <= src_tick & !halted;
         fast_clk_en <= fast_tick;
         slow_clk_en <= slow_tick;
      end
   end

   // ******************************************************************
   // Halt and wake mode control
   // ******************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_r <= MODE_RUN;
      end else begin
         unique case (mode_r)
            MODE_RUN: begin
               if (halt_req) begin                       // see R10, R14
                  unique case ({fast_keep_r, slow_keep_r})
                     2'b00:   mode_r <= MODE_SLEEP;
                     2'b01:   mode_r <= MODE_IDLE_SLOW;
                     2'b11:   mode_r <= MODE_IDLE_BOTH;
                     default: mode_r <= MODE_IDLE_FAST;
                  endcase
               end
            end
            MODE_SLEEP, MODE_IDLE_SLOW, MODE_IDLE_BOTH, MODE_IDLE_FAST: begin
               if (wake_req) begin
                  mode_r <= MODE_RUN;
               end
            end
            default: mode_r <= MODE_RUN;                 // Unused codes recover
         endcase
      end
   end

   // ******************************************************************
   // Control registers
   // ******************************************************************
   // Software writes; only implemented bits stored  see R13
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_r       <= SCC_RESET[SCC_SEL_LSB +: 3];
         fast_keep_r <= SCC_RESET[SCC_FAST_KEEP];
         slow_keep_r <= SCC_RESET[SCC_SLOW_KEEP];
         freq_sel_r  <= FRC_RESET[FRC_FREQ_LSB +: 2];
         fast_en_r   <= FRC_RESET[FRC_ENABLE];
         irq_mask_r  <= '0;
      end else if (wr_go) begin
         unique case (paddr)
            ADDR_SYS_CLK_CTRL: begin
               sel_r       <= pwdata[SCC_SEL_LSB +: 3];  // see R1
               fast_keep_r <= pwdata[SCC_FAST_KEEP];
               slow_keep_r <= pwdata[SCC_SLOW_KEEP];
            end
            ADDR_FAST_RC_CTRL: begin
               freq_sel_r <= pwdata[FRC_FREQ_LSB +: 2];  // see R5
               fast_en_r  <= pwdata[FRC_ENABLE];         // see R8
            end
            ADDR_IRQ_MASK: irq_mask_r <= pwdata[IRQ_N-1:0];
            default: ;
         endcase
      end
   end

   // ******************************************************************
   // Interrupts
   // ******************************************************************
   assign ev[EV_FAST_STAB] = !restart & fast_osc_on & !stable_r &
                             (stab_cnt_r >= FAST_STAB_CYC - STAB_W'(1));
   assign ev[EV_SW_DONE]   = (sw_r == SW_TGT) & (sel_r != cur_src_r) &
                             tgt_ready & tgt_tick;
   assign ev[EV_HALT]      = (mode_r == MODE_RUN) & halt_req;
   assign ev[EV_WAKE]      = halted & wake_req;

   // Sticky status; a new event beats a same-cycle clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_r <= '0;
      end else if (wr_go && paddr == ADDR_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_N-1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ******************************************************************
   // APB read path: one wait state, then ready with data
   // ******************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= '0;
         unique case (paddr)
            ADDR_SYS_CLK_CTRL: begin
               // Bits 4:2 and 31:8 read zero  see R13
               prdata[SCC_SEL_LSB +: 3] <= sel_r;
               prdata[SCC_FAST_KEEP]    <= fast_keep_r;
               prdata[SCC_SLOW_KEEP]    <= slow_keep_r;
            end
            ADDR_FAST_RC_CTRL: begin
               prdata[FRC_FREQ_LSB +: 2] <= freq_sel_r;
               prdata[FRC_STABLE]        <= stable_r;    // see R12
               prdata[FRC_ENABLE]        <= fast_en_r;
            end
            ADDR_STATUS: begin
               prdata[ST_SRC_LSB +: 3]  <= cur_src_r;
               prdata[ST_BUSY]          <= (sw_r != SW_IDLE);
               prdata[ST_MODE_LSB +: 3] <= mode_r;
               prdata[ST_SLOW_STAB]     <= slow_stable_r;
            end
            ADDR_IRQ_STAT: prdata[IRQ_N-1:0] <= irq_stat_r;
            ADDR_IRQ_MASK: prdata[IRQ_N-1:0] <= irq_mask_r;
            default:       pslverr <= 1'b1;              // Unmapped address
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : scmc_clock_ctrl

/* verification/scmc_props.sv */
// Checker: port-level properties of the clock control block
`timescale 1ns/1ps
module scmc_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sys_clk_en,
   input wire logic cpu_clk_en,
   input wire logic fast_clk_en,
   input wire logic slow_clk_en,
   input wire logic fast_osc_on,
   input wire logic slow_osc_on
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!resetn);
   // ****************************************
   // Bus answer sequences
   // ****************************************
   sequence acc_s;
      psel && penable && !pready;
   endsequence
   sequence ans_s;
      pready ##1 !pready;
   endsequence
   ready_follows_a: assert property (acc_s |=> ans_s)
      else $error("ready not one cycle after access");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("ready without access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   // ****************************************
   // Clock pulse shape
   // ****************************************
   sys_pulse_a: assert property (sys_clk_en |=> !sys_clk_en [*2])
      else $error("system pulse too close");
   cpu_gated_a: assert property (cpu_clk_en |-> sys_clk_en)
      else $error("processor pulse without system pulse");
   fast_pulse_a: assert property (fast_clk_en |=> !fast_clk_en [*2])
      else $error("fast pulse too close");
   slow_pulse_a: assert property (slow_clk_en |=> !slow_clk_en [*8])
      else $error("slow pulse too close");
   slow_stop_a: assert property ($fell(slow_osc_on) |=> !slow_clk_en [*8])
      else $error("slow pulse after stop");
   fast_stop_a: assert property ($fell(fast_osc_on) |=> !fast_clk_en [*8])
      else $error("fast pulse after stop");
endmodule : scmc_props

bind scmc_clock_ctrl scmc_props props_inst (.clk, .resetn, .psel, .penable, .pready,
   .pslverr, .sys_clk_en, .cpu_clk_en, .fast_clk_en, .slow_clk_en, .fast_osc_on,
   .slow_osc_on);

/* verification/scmc_core_model.sv */
// Partner: processor core issuing register accesses, halt and wake
`timescale 1ns/1ps
module scmc_core_model
   import scmc_pkg::*;
(
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             halt_req,
   output logic             wake_req
);
   initial {psel, penable, pwrite, paddr, pwdata, halt_req, wake_req} = '0;
   // One bus transfer, request held until ready is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   // Halt (h=1) or wake (h=0) pulse of one cycle
   task automatic pulse(input logic h);
      @(posedge clk);
      if (h) halt_req <= 1'b1;
      else wake_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      wake_req <= 1'b0;
   endtask : pulse
   // Software waits on a flag before relying on a clock
   task automatic poll(input logic [7:0] a, input int b, input logic v,
                       output logic [31:0] rd);
      logic e;
      do xfer(1'b0, a, 32'h0, rd, e); while (rd[b] !== v);
   endtask : poll
endmodule : scmc_core_model

/* verification/system_clock_mode_control_test.sv */
// Testbench: registers, halt modes, clock switching and interrupt
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module system_clock_mode_control_test;
   import scmc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, halt_req, wake_req, err, irq;
   logic sys_clk_en, cpu_clk_en, fast_clk_en, slow_clk_en, fast_osc_on, slow_osc_on;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [2:0] sel;
   int mismatches = 0, cmp_count = 0, cyc = 0, gap, seed = 32'h012b;
   always #10 clk = ~clk;
   scmc_clock_ctrl scmc_clock_ctrl_inst (.clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .halt_req, .wake_req, .sys_clk_en,
      .cpu_clk_en, .fast_clk_en, .slow_clk_en, .fast_osc_on, .slow_osc_on, .irq);
   scmc_core_model scmc_core_model_inst (.clk, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .halt_req, .wake_req);
   function automatic logic [2:0] mode_of(input int k);
      case (k)
         0: return MODE_SLEEP;
         1: return MODE_IDLE_SLOW;
         3: return MODE_IDLE_BOTH;
         default: return MODE_IDLE_FAST;
      endcase
   endfunction : mode_of
   function automatic int per_of(input logic [2:0] s);
      return (s == SEL_SLOW) ? int'(SLOW_PER) : int'(FAST_PER_12) << s;
   endfunction : per_of
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      scmc_core_model_inst.xfer(1'b1, a, d, rdv, err);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      scmc_core_model_inst.xfer(1'b0, a, 32'h0, rdv, err);
   endtask : rd
   task automatic test_done();
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         $display("BAD timeout exp 0 got %0d", cyc);
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rd(ADDR_SYS_CLK_CTRL);
      `CHK("scc_rst", 32'h0, rdv)
      rd(ADDR_FAST_RC_CTRL);
      `CHK("frc_rst", 32'h1, rdv)
      scmc_core_model_inst.poll(ADDR_FAST_RC_CTRL, FRC_STABLE, 1'b1, rdv);
      wr(ADDR_FAST_RC_CTRL, 32'hFFFFFFF5); // 12 MHz to match setting
      rd(ADDR_FAST_RC_CTRL);
      `CHK("frc_chg", 32'h5, rdv)
      scmc_core_model_inst.poll(ADDR_FAST_RC_CTRL, FRC_STABLE, 1'b1, rdv);
      `CHK("frc_stab", 32'h7, rdv)
      wr(ADDR_SYS_CLK_CTRL, 32'hFFFFFF1F);
      rd(ADDR_SYS_CLK_CTRL);
      `CHK("scc_wr", 32'h3, rdv)
      rd(8'h14);
      `CHK("unmapped", 33'h100000000, {err, rdv})
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_SYS_CLK_CTRL, k);
         scmc_core_model_inst.pulse(1'b1);
         repeat (3) @(posedge clk);
         `CHK("fast_on", k[1], fast_osc_on)
         `CHK("slow_on", k[0], slow_osc_on)
         `CHK("cpu_off", 1'b0, cpu_clk_en)
         if (!k[1]) `CHK("fast_clk", 1'b0, fast_clk_en)
         if (!k[0]) `CHK("slow_clk", 1'b0, slow_clk_en)
         rd(ADDR_STATUS);
         `CHK("mode", mode_of(k), rdv[6:4])
         scmc_core_model_inst.pulse(1'b0);
         repeat (3) @(posedge clk);
         `CHK("fast_run", 1'b1, fast_osc_on)
      end
      rd(ADDR_IRQ_STAT);
      `CHK("halt_wake", 2'h3, rdv[3:2])
      wr(ADDR_IRQ_STAT, 32'hF);
      for (int j = 0; j < 4; j++) begin
         sel = (j == 0) ? 3'(1 + $unsigned($random(seed)) % 6) : 3'((j + 5) % 8);
         if (j == 2) wr(ADDR_FAST_RC_CTRL, 32'h4);
         wr(ADDR_SYS_CLK_CTRL, {24'h0, sel, 5'h0});
         scmc_core_model_inst.poll(ADDR_STATUS, ST_BUSY, 1'b0, rdv);
         `CHK("act_sel", sel, rdv[2:0])
         while (sys_clk_en !== 1'b1) @(posedge clk);
         gap = 0;
         do begin @(posedge clk); gap++; end while (sys_clk_en !== 1'b1);
         `CHK("period", per_of(sel), gap)
         if (j == 2) `CHK("fast_stop", 1'b0, fast_osc_on)
         if (j == 2) `CHK("fast_quiet", 1'b0, fast_clk_en)
      end
      `CHK("irq_mask", 1'b0, irq)
      rd(ADDR_IRQ_STAT);
      `CHK("sw_done", 1'b1, rdv[EV_SW_DONE])
      wr(ADDR_IRQ_MASK, 32'h2);
      repeat (2) @(posedge clk);
      `CHK("irq_on", 1'b1, irq)
      wr(ADDR_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      `CHK("irq_clr", 1'b0, irq)
      test_done();
   end
endmodule : system_clock_mode_control_test
